// ==== fpmv_cfg.svh ====
// Constants for the floating-point move instruction unit
// Assumes inclusion by the single design file; the package does not include it
`ifndef FPMV_CFG_SVH
`define FPMV_CFG_SVH
`define FPMV_NREG      8
`define FPMV_XW        80
`define FPMV_MEMW      96
`define FPMV_RIDXW     3
`define FPMV_MASK_ZERO 8'h00
`define FPMV_EXT_ZERO  80'h0
`define FPMV_MEM_ZERO  96'h0
`define FPMV_PAD_ZERO  16'h0
`define FPMV_EMAX      15'h7fff
`define FPMV_EBIAS     15'h3fff
`define FPMV_EMIN_S    15'h3f81
`define FPMV_EMAX_S    15'h407e
`define FPMV_EMIN_D    15'h3c01
`define FPMV_EMAX_D    15'h43fe
`define FPMV_MAN_S_LSB 40
`define FPMV_MAN_D_LSB 11
`define FPMV_EXPW        15
`define FPMV_SIGN        79
`define FPMV_EXP_MSB     78
`define FPMV_EXP_LSB     64
`define FPMV_MAN_MSB     63
`define FPMV_IMG_MSB     95
`define FPMV_IMG_EXP_LSB 80
`define FPMV_EXP_ONE     15'h1
`define FPMV_EXP_ZERO    15'h0
`define FPMV_MAN_ZERO    64'h0
`endif

// ==== fpmv_pkg.sv ====
// Types for the floating-point move instruction unit
// Assumes fpmv_cfg.svh is compiled alongside
package fpmv_pkg;
  typedef enum logic [2:0] {
    FPMV_OP_IN,
    FPMV_OP_OUT,
    FPMV_OP_REG,
    FPMV_OP_MONADIC,
    FPMV_OP_MULTI_IN,
    FPMV_OP_MULTI_OUT
  } fpmv_op_t;
  typedef enum logic [1:0] {
    FPMV_PREC_EXT,
    FPMV_PREC_SGL,
    FPMV_PREC_DBL
  } fpmv_prec_t;
  typedef enum logic [1:0] {
    FPMV_RND_NEAR,
    FPMV_RND_ZERO,
    FPMV_RND_MINUS,
    FPMV_RND_PLUS
  } fpmv_rnd_t;
  typedef enum logic [1:0] {
    FPMV_SRC_FPREG,
    FPMV_SRC_MEM,
    FPMV_SRC_HOSTREG
  } fpmv_src_t;
endpackage : fpmv_pkg

// ==== fpmv_unit.sv ====
// Floating-point move instruction unit: single, multiple and monadic moves
// Assumes the host supplies operands already aligned; one clock, sync reset
//
// Overview of operation
// - Inbound moves convert source format into internal extended precision.
// - Outbound moves convert extended precision into the requested destination format.
// - Single moves round in control mode to control precision, or to a non-extended outbound destination format; flag overflow and underflow.
// - Multi-register move transfers any subset of eight data registers.
// - Multi-register move carries 96-bit extended data exactly as held.
// - Register list comes from the instruction or a host data register.
// - Multi-register move never rounds nor checks overflow or underflow.
// - Monadic operand from fp register, memory or host; result to fp register.
// - Data registers hold only extended precision values.
`include "fpmv_cfg.svh"
module fpmv_unit (
  input  wire logic                       core_clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       start_i,
  input  wire fpmv_pkg::fpmv_op_t         op_i,
  input  wire fpmv_pkg::fpmv_src_t        src_sel_i,
  input  wire fpmv_pkg::fpmv_prec_t       src_fmt_i,
  input  wire fpmv_pkg::fpmv_prec_t       dst_fmt_i,
  input  wire logic [`FPMV_RIDXW-1:0]     source_fp_register_i,
  input  wire logic [`FPMV_RIDXW-1:0]     destination_fp_register_i,
  input  wire logic [`FPMV_XW-1:0]        operand_i,
  input  wire fpmv_pkg::fpmv_prec_t       ctl_prec_i,
  input  wire fpmv_pkg::fpmv_rnd_t        ctl_rnd_i,
  input  wire logic                       list_from_host_i,
  input  wire logic [`FPMV_NREG-1:0]      list_instr_i,
  input  wire logic [`FPMV_NREG-1:0]      list_host_i,
  input  wire logic [`FPMV_MEMW-1:0]      mem_wdata_i,
  input  wire logic                       mem_ready_i,
  output logic                            busy_o,
  output logic                            done_o,
  output logic [`FPMV_XW-1:0]             result_o,
  output logic                            result_valid_o,
  output logic                            ovfl_o,
  output logic                            unfl_o,
  output logic                            mem_valid_o,
  output logic [`FPMV_RIDXW-1:0]          mem_reg_o,
  output logic [`FPMV_MEMW-1:0]           mem_rdata_o
);
  // ****************************************
  // Conversion and rounding helpers
  // ****************************************
  function automatic logic [`FPMV_EXPW-1:0] fpmv_exp(input logic [`FPMV_XW-1:0] x);
    fpmv_exp = x[`FPMV_EXP_MSB:`FPMV_EXP_LSB];
  endfunction : fpmv_exp

  function automatic logic [`FPMV_MEMW-1:0] fpmv_to_img(input logic [`FPMV_XW-1:0] x);
    fpmv_to_img = {x[`FPMV_SIGN:`FPMV_EXP_LSB], `FPMV_PAD_ZERO, x[`FPMV_MAN_MSB:0]};
  endfunction : fpmv_to_img

  function automatic logic [`FPMV_XW-1:0] fpmv_from_img(input logic [`FPMV_MEMW-1:0] w);
    fpmv_from_img = {w[`FPMV_IMG_MSB:`FPMV_IMG_EXP_LSB], w[`FPMV_MAN_MSB:0]};
  endfunction : fpmv_from_img

  function automatic logic [`FPMV_XW-1:0] fpmv_round(
    input logic [`FPMV_XW-1:0] x, input fpmv_pkg::fpmv_prec_t p,
    input fpmv_pkg::fpmv_rnd_t r);
    logic [63:0] m;
    logic [64:0] s;
    logic [63:0] keep;
    logic [63:0] half;
    logic        up;
    int          lsb;
    m    = x[`FPMV_MAN_MSB:0];
    lsb  = (p == fpmv_pkg::FPMV_PREC_SGL) ? `FPMV_MAN_S_LSB :
           (p == fpmv_pkg::FPMV_PREC_DBL) ? `FPMV_MAN_D_LSB : 0;
    keep = ~64'h0 << lsb;
    half = (lsb == 0) ? 64'h0 : (64'h1 << (lsb - 1));
    up   = 1'b0;
    unique case (r)
      fpmv_pkg::FPMV_RND_NEAR:  up = (lsb != 0) && ((m & ~keep) >= half);
      fpmv_pkg::FPMV_RND_ZERO:  up = 1'b0;
      fpmv_pkg::FPMV_RND_MINUS: up = x[`FPMV_SIGN] && ((m & ~keep) != `FPMV_MAN_ZERO);
      fpmv_pkg::FPMV_RND_PLUS:  up = !x[`FPMV_SIGN] && ((m & ~keep) != `FPMV_MAN_ZERO);
    endcase
    s = {1'b0, m & keep} + (up ? {1'b0, ~keep + 64'h1} : 65'h0);
    if (s[`FPMV_MAN_MSB+1]) begin
      fpmv_round = {x[`FPMV_SIGN], fpmv_exp(x) + `FPMV_EXP_ONE, 1'b1, s[`FPMV_MAN_MSB:1]};
    end else begin
      fpmv_round = {x[`FPMV_SIGN:`FPMV_EXP_LSB], s[`FPMV_MAN_MSB:0]};
    end
  endfunction : fpmv_round

  function automatic logic fpmv_ovf(input logic [`FPMV_XW-1:0] x,
                                    input fpmv_pkg::fpmv_prec_t p);
    fpmv_ovf = (p == fpmv_pkg::FPMV_PREC_SGL) ? (fpmv_exp(x) > `FPMV_EMAX_S) :
               (p == fpmv_pkg::FPMV_PREC_DBL) ? (fpmv_exp(x) > `FPMV_EMAX_D) :
               (fpmv_exp(x) == `FPMV_EMAX);
  endfunction : fpmv_ovf

  function automatic logic fpmv_unf(input logic [`FPMV_XW-1:0] x,
                                    input fpmv_pkg::fpmv_prec_t p);
    logic nz;
    nz = (x[`FPMV_MAN_MSB:0] != `FPMV_MAN_ZERO);
    fpmv_unf = nz && ((p == fpmv_pkg::FPMV_PREC_SGL) ? (fpmv_exp(x) < `FPMV_EMIN_S) :
                      (p == fpmv_pkg::FPMV_PREC_DBL) ? (fpmv_exp(x) < `FPMV_EMIN_D) :
                      (fpmv_exp(x) == `FPMV_EXP_ZERO));
  endfunction : fpmv_unf

  // ****************************************
  // Data registers and multi-move state
  // ****************************************
  logic [`FPMV_XW-1:0]    fp_data_q [`FPMV_NREG];
  logic [`FPMV_NREG-1:0]  mask_q, mask_d;
  logic                   multi_q, multi_d;
  logic                   mdir_in_q;
  logic [`FPMV_RIDXW-1:0] cur_idx;
  logic [`FPMV_NREG-1:0]  low_bit;
  logic [`FPMV_XW-1:0]    src_val;
  logic [`FPMV_XW-1:0]    rounded;
  logic                   is_single;
  logic                   is_multi;
  logic                   step;
  logic                   multi_start;
  logic                   mask_empty;
  logic                   is_out;
  fpmv_pkg::fpmv_prec_t   round_prec;
  logic                   ovf_now;
  logic                   unf_now;

  assign is_multi  = (op_i == fpmv_pkg::FPMV_OP_MULTI_IN) ||
                     (op_i == fpmv_pkg::FPMV_OP_MULTI_OUT);
  assign is_single = start_i && !multi_q && !is_multi;
  assign multi_start = start_i && !multi_q && is_multi;
  assign mask_empty  = (mask_q == `FPMV_MASK_ZERO);
  assign is_out      = (op_i == fpmv_pkg::FPMV_OP_OUT);
  // Lowest selected register goes first
  assign low_bit   = mask_q & (~mask_q + 8'h01);
  always_comb begin
    cur_idx = '0;
    for (int i = 0; i < `FPMV_NREG; i++) begin
      if (low_bit[i]) begin
        cur_idx = i[`FPMV_RIDXW-1:0];
      end
    end
  end
  assign step = multi_q && !mask_empty && mem_ready_i;

  // Operand source selection; memory/host operands arrive as extended after conversion
  assign src_val = (is_out || op_i == fpmv_pkg::FPMV_OP_REG ||
                    src_sel_i == fpmv_pkg::FPMV_SRC_FPREG) ?
                   fp_data_q[source_fp_register_i] :
                   fpmv_round(operand_i, src_fmt_i, fpmv_pkg::FPMV_RND_NEAR);
  assign round_prec = (is_out && dst_fmt_i != fpmv_pkg::FPMV_PREC_EXT) ?
                      dst_fmt_i : ctl_prec_i;
  assign rounded = fpmv_round(src_val, round_prec, ctl_rnd_i);
  assign ovf_now = fpmv_ovf(rounded, ctl_prec_i) ||
                   (is_out && fpmv_ovf(rounded, dst_fmt_i));
  assign unf_now = fpmv_unf(rounded, ctl_prec_i) ||
                   (is_out && fpmv_unf(rounded, dst_fmt_i));

  // ****************************************
  // Multi-move mask sequencing
  // ****************************************

  always_comb begin
    mask_d  = mask_q;
    multi_d = multi_q;
    if (multi_start) begin
      mask_d  = list_from_host_i ? list_host_i : list_instr_i;
      multi_d = 1'b1;
    end else if (step) begin
      mask_d = mask_q & ~low_bit;
    end else if (multi_q && mask_empty) begin
      multi_d = 1'b0;
    end
  end

  // ****************************************
  // Sequential state
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mask_q         <= `FPMV_MASK_ZERO;
      multi_q        <= 1'b0;
      mdir_in_q      <= 1'b0;
      done_o         <= 1'b0;
      result_o       <= `FPMV_EXT_ZERO;
      result_valid_o <= 1'b0;
      ovfl_o         <= 1'b0;
      unfl_o         <= 1'b0;
      mem_valid_o    <= 1'b0;
      mem_reg_o      <= '0;
      mem_rdata_o    <= `FPMV_MEM_ZERO;
      for (int i = 0; i < `FPMV_NREG; i++) begin
        fp_data_q[i] <= `FPMV_EXT_ZERO;
      end
    end else begin
      mask_q         <= mask_d;
      multi_q        <= multi_d;
      done_o         <= (multi_q && mask_empty) || is_single;
      result_valid_o <= is_single;
      mem_valid_o    <= step && !mdir_in_q;
      if (multi_start) begin
        mdir_in_q <= (op_i == fpmv_pkg::FPMV_OP_MULTI_IN);
      end
      if (is_single) begin
        result_o <= rounded;
        ovfl_o   <= ovf_now;
        unfl_o   <= unf_now;
        if (!is_out) begin
          fp_data_q[destination_fp_register_i] <= rounded;
        end
      end
      if (step) begin
        mem_reg_o <= cur_idx;
        // Raw 96-bit image, no rounding or range check
        if (mdir_in_q) begin
          fp_data_q[cur_idx] <= fpmv_from_img(mem_wdata_i);
        end else begin
          mem_rdata_o <= fpmv_to_img(fp_data_q[cur_idx]);
        end
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign busy_o = multi_q;
endmodule : fpmv_unit

// ==== fpmv_properties.sv ====
// Checker for the move unit handshake and flags
// Assumes binding onto fpmv_unit
module fpmv_properties (
  input wire logic               core_clk_i,
  input wire logic               sys_rst_i,
  input wire logic               start_i,
  input wire fpmv_pkg::fpmv_op_t op_i,
  input wire logic               mem_ready_i,
  input wire logic               busy_o,
  input wire logic               done_o,
  input wire logic               result_valid_o,
  input wire logic               ovfl_o,
  input wire logic               unfl_o,
  input wire logic               mem_valid_o,
  input wire logic [2:0]         mem_reg_o
);
  // ****
  // Assertions
  // ****
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire go = start_i && !busy_o;
  wire multi = op_i inside {fpmv_pkg::FPMV_OP_MULTI_IN, fpmv_pkg::FPMV_OP_MULTI_OUT};
  sequence s_single; go && !multi; endsequence
  sequence s_multi; go && multi; endsequence
  a_single_done_next: assert property (s_single |=> done_o && result_valid_o)
    else $error("single move not answered");
  a_multi_sets_busy: assert property (s_multi |=> busy_o)
    else $error("multiple move not busy");
  a_multi_bounded: assert property (s_multi |-> ##[2:40] done_o)
    else $error("multiple move never done");
  a_valid_needs_ready: assert property (mem_valid_o |-> $past(mem_ready_i) && $past(busy_o))
    else $error("word without step");
  a_valid_in_busy: assert property (mem_valid_o |-> busy_o)
    else $error("word outside move");
  a_reg_order_up: assert property (mem_valid_o ##1 mem_valid_o |-> mem_reg_o > $past(mem_reg_o))
    else $error("registers out of order");
  a_no_round_multi: assert property (busy_o |=> $stable(ovfl_o) && $stable(unfl_o) && !result_valid_o)
    else $error("flags moved in multiple move");
  a_done_on_fall: assert property ($fell(busy_o) |-> done_o)
    else $error("busy fell without done");
endmodule : fpmv_properties
bind fpmv_unit fpmv_properties fpmv_properties_inst (.core_clk_i(core_clk_i),
  .sys_rst_i(sys_rst_i), .start_i(start_i), .op_i(op_i), .mem_ready_i(mem_ready_i),
  .busy_o(busy_o), .done_o(done_o), .result_valid_o(result_valid_o), .ovfl_o(ovfl_o),
  .unfl_o(unfl_o), .mem_valid_o(mem_valid_o), .mem_reg_o(mem_reg_o));

// ==== fpmv_host_model.sv ====
// Host memory side of multiple moves, prompt or stalling
// Assumes step k of an inbound move carries register image k
module fpmv_host_model (
  input  wire logic  core_clk_i,
  input  wire logic  busy_i,
  input  wire logic  slow_i,
  output logic       mem_ready_o,
  output logic [95:0] mem_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] k_q = 3'h0;
  logic       ph_q = 1'b0;
  function automatic logic [95:0] img(input logic [2:0] k);
    return {4'h4, 9'h0, k, 16'h0000, 1'b1, k, 60'h123_4567_89ab_cdef};
  endfunction : img
  assign mem_ready_o = !slow_i || ph_q;
  assign mem_wdata_o = busy_i ? img(k_q) : ~img(k_q);
  always_ff @(posedge core_clk_i) begin
    ph_q <= !ph_q;
    k_q <= busy_i ? k_q + {2'h0, mem_ready_o} : 3'h0;
  end
endmodule : fpmv_host_model

// ==== tb_top.sv ====
// Self-checking bench for the move unit
// Assumes the host model feeds memory words
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, start_i = 1'b0, list_from_host_i = 1'b0;
  logic slow = 1'b0;
  fpmv_pkg::fpmv_op_t op_i = fpmv_pkg::FPMV_OP_IN;
  fpmv_pkg::fpmv_src_t src_sel_i = fpmv_pkg::FPMV_SRC_MEM;
  fpmv_pkg::fpmv_prec_t dst_fmt_i = fpmv_pkg::FPMV_PREC_EXT, ctl_prec_i = fpmv_pkg::FPMV_PREC_EXT;
  fpmv_pkg::fpmv_rnd_t ctl_rnd_i = fpmv_pkg::FPMV_RND_NEAR;
  logic [2:0] src_reg = 3'h0, mem_reg_o;
  logic [2:0] dst_reg = 3'h1;
  fpmv_pkg::fpmv_prec_t src_fmt = fpmv_pkg::FPMV_PREC_EXT;
  logic [79:0] operand_i = 80'h0, result_o;
  logic [7:0] list_instr_i = 8'h00, list_host_i = 8'h00;
  logic mem_ready_i, busy_o, done_o, result_valid_o, ovfl_o, unfl_o, mem_valid_o;
  logic [95:0] mem_wdata_i, mem_rdata_o;
  logic [98:0] seen_q[$];
  logic [2:0] exp_r[4] = '{3'h0, 3'h2, 3'h5, 3'h7};
  logic [63:0] rnd_exp[4] = '{64'h8000_0000_0000_0000, 64'h8000_0000_0000_0000,
                              64'h8000_0000_0000_0000, 64'h8000_0100_0000_0000};
  int n_mismatch = 0, compares = 0;
  fpmv_unit fpmv_unit_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
    .op_i(op_i), .src_sel_i(src_sel_i), .src_fmt_i(src_fmt), .dst_fmt_i(dst_fmt_i),
    .source_fp_register_i(src_reg), .destination_fp_register_i(dst_reg), .operand_i(operand_i),
    .ctl_prec_i(ctl_prec_i), .ctl_rnd_i(ctl_rnd_i), .list_from_host_i(list_from_host_i),
    .list_instr_i(list_instr_i), .list_host_i(list_host_i), .mem_wdata_i(mem_wdata_i),
    .mem_ready_i(mem_ready_i), .busy_o(busy_o), .done_o(done_o), .result_o(result_o),
    .result_valid_o(result_valid_o), .ovfl_o(ovfl_o), .unfl_o(unfl_o),
    .mem_valid_o(mem_valid_o), .mem_reg_o(mem_reg_o), .mem_rdata_o(mem_rdata_o));
  fpmv_host_model fpmv_host_model_inst (.core_clk_i(core_clk_i), .busy_i(busy_o),
    .slow_i(slow), .mem_ready_o(mem_ready_i), .mem_wdata_o(mem_wdata_i));
  initial forever #5 core_clk_i = ~core_clk_i;
  always @(negedge core_clk_i) if (mem_valid_o === 1'b1) seen_q.push_back({mem_reg_o, mem_rdata_o});
  task automatic chk(input logic [98:0] seen, input logic [98:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic single(input fpmv_pkg::fpmv_op_t op, input logic [79:0] opnd);
    @(negedge core_clk_i);
    op_i = op;
    operand_i = opnd;
    start_i = 1'b1;
    @(negedge core_clk_i);
    start_i = 1'b0;
    chk(99'({done_o, result_valid_o}), 99'h3);
    @(negedge core_clk_i);
    chk(99'({done_o, result_valid_o}), 99'h0);
  endtask : single
  task automatic multi(input fpmv_pkg::fpmv_op_t op, input logic host, input logic [7:0] mask);
    @(negedge core_clk_i);
    op_i = op;
    list_from_host_i = host;
    list_host_i = host ? mask : ~mask;
    list_instr_i = host ? ~mask : mask;
    seen_q = {};
    start_i = 1'b1;
    @(negedge core_clk_i);
    start_i = 1'b0;
    for (int i = 0; i < 60 && done_o !== 1'b1; i++) @(posedge core_clk_i) #1;
    chk(99'(done_o), 99'h1);
    @(negedge core_clk_i);
  endtask : multi
  task automatic end_of_test();
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (20) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    slow = 1'b1;
    ctl_prec_i = fpmv_pkg::FPMV_PREC_SGL;
    multi(fpmv_pkg::FPMV_OP_MULTI_IN, 1'b0, 8'hff);
    slow = 1'b0;
    multi(fpmv_pkg::FPMV_OP_MULTI_OUT, 1'b1, 8'ha5);
    chk(99'(seen_q.size()), 99'h4);
    foreach (seen_q[i]) chk(seen_q[i], {exp_r[i], fpmv_host_model_inst.img(exp_r[i])});
    multi(fpmv_pkg::FPMV_OP_MULTI_OUT, 1'b0, 8'h00);
    chk(99'(seen_q.size()), 99'h0);
    ctl_prec_i = fpmv_pkg::FPMV_PREC_EXT;
    src_reg = 3'h3;
    src_sel_i = fpmv_pkg::FPMV_SRC_FPREG;
    single(fpmv_pkg::FPMV_OP_REG, 80'h0);
    chk(99'(result_o), {19'h0, 16'h4003, 64'hb123_4567_89ab_cdef});
    dst_fmt_i = fpmv_pkg::FPMV_PREC_SGL;
    single(fpmv_pkg::FPMV_OP_OUT, 80'h0);
    chk(99'(result_o), {19'h0, 16'h4003, 64'hb123_4500_0000_0000});
    dst_fmt_i = fpmv_pkg::FPMV_PREC_EXT;
    ctl_prec_i = fpmv_pkg::FPMV_PREC_SGL;
    src_sel_i = fpmv_pkg::FPMV_SRC_MEM;
    foreach (rnd_exp[i]) begin
      ctl_rnd_i = fpmv_pkg::fpmv_rnd_t'(i);
      single(fpmv_pkg::FPMV_OP_IN, {16'h3fff, 64'h8000_0000_0000_0001});
      chk(99'(result_o), {19'h0, 16'h3fff, rnd_exp[i]});
    end
    single(fpmv_pkg::FPMV_OP_IN, {16'h5000, 64'h8000_0000_0000_0000});
    chk(99'({ovfl_o, unfl_o}), 99'h2);
    single(fpmv_pkg::FPMV_OP_IN, {16'h3000, 64'h8000_0000_0000_0000});
    chk(99'({ovfl_o, unfl_o}), 99'h1);
    ctl_prec_i = fpmv_pkg::FPMV_PREC_EXT;
    src_fmt = fpmv_pkg::FPMV_PREC_SGL;
    src_sel_i = fpmv_pkg::FPMV_SRC_HOSTREG;
    dst_reg = 3'h6;
    single(fpmv_pkg::FPMV_OP_MONADIC, {16'h3fff, 64'h8000_0000_0000_0001});
    chk(99'(result_o), {19'h0, 16'h3fff, 64'h8000_0000_0000_0000});
    multi(fpmv_pkg::FPMV_OP_MULTI_OUT, 1'b0, 8'h40);
    chk(99'(seen_q.size()), 99'h1);
    chk(seen_q[0], {3'h6, 16'h3fff, 16'h0, 64'h8000_0000_0000_0000});
    end_of_test();
  end
endmodule : tb_top
